/* File: core/lpim_pkg.sv */
// Shared constants and types for the low-power DDR init and mode-load block.
// Assumes one 100 MHz clock and an APB master reaching the status registers.
// Behaviour
// R1: High clock gate enables clocks, input buffers, drivers; low disables them.
// R2: Clock gate low with banks idle: precharge power down or self refresh.
// R3: Clock gate sampled synchronously, except self refresh exit, taken at once.
// R4: In power down and self refresh only clock and gate buffers stay on.
// R5: Device drives strobe with read data; controller strobes write data.
// R6: One strobe per byte lane: two lanes narrow, four lanes wide.
// R7: Narrow part uses ten column bits, four banks, two bank bits.
// R8: Wide part uses nine column bits, thirteen row bits.
// R9: Controller holds clock gate high from power-up before clocking.
// R10: Controller gives 200 us of clock with only idle commands first.
// R11: Controller issues precharge-all then idles for the precharge wait.
// R12: Two auto refreshes, each followed by the refresh cycle wait.
// R13: Controller loads base and extended mode, each then mode load wait.
// R14: Mode registers have no default; both must be loaded at init.
// R15: Clock stop is not allowed before initialization completes.
// R16: After power loss the controller repeats full initialization.
// R17: Mode load with both bank select bits zero targets base register.
// R18: Base mode kept until rewritten, deep power down, or power loss.
// R19: Mode bits 0-2 burst length, bit 3 burst type, 4-6 read latency.
// R20: Controller writes zero to undefined bits, avoids reserved codes.
// R21: Mode load only with all banks idle; then wait mode load time.
// R22: During mode load the address pins carry the opcode.
// R23: Commands accepted only with chip select low; ignored when high.
// R24: Controller keeps the three waits as configurable cycle counts.
// R25: Flag any non-idle command before stable clock and init complete; code lets precharge, refresh and mode load pass during setup.
package lpim_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int STABLE_CLK_US = 200;
    localparam int STABLE_CLK_CYC = STABLE_CLK_US * CLK_MHZ;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MODE = 8'h08;
    localparam logic [7:0] REG_BANKS = 8'h0c;
    localparam int CTRL_WIDE_BIT = 0;
    localparam int CTRL_ERRCLR_BIT = 1;

    // ----------------------------------------
    // Array geometry and pin fields
    // ----------------------------------------
    localparam int ROW_W = 13;
    localparam int COL_W16 = 10;
    localparam int COL_W32 = 9;
    localparam int BANKS = 4;
    localparam int LANES = 4;
    localparam logic [3:0] LANES_X16 = 4'h3;
    localparam logic [3:0] LANES_X32 = 4'hf;
    localparam int AP_BIT = 10;
    localparam logic [1:0] BA_BASE = 2'h0;
    localparam logic [1:0] BA_EXT = 2'h2;
    localparam logic [1:0] REF_NEED = 2'h2;

    // Base mode fields
    localparam int MR_BL_LSB = 0;
    localparam int MR_BT_BIT = 3;
    localparam int MR_RL_LSB = 4;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_16 = 3'h4;

    // Command codes on row strobe, column strobe, write enable
    localparam logic [2:0] OP_MODE_LOAD = 3'h0;
    localparam logic [2:0] OP_REF = 3'h1;
    localparam logic [2:0] OP_PRE = 3'h2;
    localparam logic [2:0] OP_ACT = 3'h3;
    localparam logic [2:0] OP_WR = 3'h4;
    localparam logic [2:0] OP_RD = 3'h5;
    localparam logic [2:0] OP_BST = 3'h6;
    localparam logic [2:0] OP_NOP = 3'h7;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        PW_ON, PW_PRE_PD, PW_ACT_PD, PW_SELF_REF, PW_DEEP_PD
    } lpim_pwr_t;

    typedef enum logic [1:0] {
        IN_STABLE, IN_PRECHARGE, IN_SETUP, IN_READY
    } lpim_init_t;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [1:0] ba;
        logic [ROW_W-1:0] addr;
    } lpim_cmd_t;

    typedef struct packed {
        logic [19:0] pad;
        logic clk_stop_ok;
        lpim_pwr_t pwr;
        logic stable_done;
        logic pre_seen;
        logic [1:0] ref_cnt;
        logic ext_valid;
        logic base_valid;
        logic err;
        logic init_done;
    } lpim_status_t;

    typedef struct packed {
        logic valid;
        logic [17:0] pad;
        logic [ROW_W-1:0] opcode;
    } lpim_mode_rd_t;

endpackage

/* File: core/lpim_cycle_timer.sv */
// Counts clock cycles up to a limit and then holds a done level.
// Assumes a synchronous restart from the owning block.
`timescale 1ns/1ps
module lpim_cycle_timer #(
    parameter int CYCLES = 16 // Cycles until done
) (
    input wire logic clk, // Block clock
    input wire logic rst_n, // Async reset, active low
    input wire logic restart, // Start counting again from zero
    output logic done // Limit reached, level
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES);

    logic [CW-1:0] cnt_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (restart) begin
            cnt_q <= '0;
        end else if (cnt_q != LAST) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign done = (cnt_q == LAST);

endmodule

/* File: core/lpim_core.sv */
// Device-side command tracker: power states, init sequence, base mode load.
// Assumes command pins are synchronous to pclk and APB master on pclk.
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module lpim_core #(
    parameter int STABLE_CYCLES = lpim_pkg::STABLE_CLK_CYC // Stable clock wait
) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped
    input wire logic mem_cke, // Clock gate input
    input wire lpim_pkg::lpim_cmd_t mem_cmd, // Command and address pins
    output logic clk_en, // Internal clocks running
    output logic inbuf_en, // Non-clock input buffers on
    output logic outdrv_en, // Output drivers on
    output logic [3:0] strobe_oe, // Byte lane strobe drive
    output logic [9:0] col_addr, // Last column address
    output logic [12:0] row_addr, // Last row address
    output logic cmd_err // Sticky protocol error
);
    import lpim_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    lpim_pwr_t pwr_q, pwr_d;
    lpim_init_t init_q, init_d;
    logic cke_q;
    logic [BANKS-1:0] open_q, open_d;
    logic [1:0] ref_cnt_q;
    logic base_valid_q, ext_valid_q;
    logic [ROW_W-1:0] mode_q;
    logic err_q;
    logic wide_q;
    logic [3:0] rd_cnt_q;
    logic [3:0] rd_cnt_d;
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;
    logic clk_en_q, inbuf_en_q, outdrv_en_q;
    logic [3:0] strobe_oe_q;
    logic [9:0] col_addr_q;
    logic [ROW_W-1:0] row_addr_q;

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    logic [2:0] op_w;
    logic live_w, fall_w, idle_w;
    logic pall_w, pre_w, ref_w, mload_w, act_w, rd_w, wr_w, bst_w;
    logic stable_done_w, leave_dpd_w, rd_start_w;
    logic early_w, stop_early_w, ml_busy_w, bad_w;
    logic [3:0] beats_w, lane_mask_w;

    assign op_w = {mem_cmd.ras_n, mem_cmd.cas_n, mem_cmd.we_n};
    // Chip select high masks every decoded command, not power down entry or exit; see R23
    assign live_w = !mem_cmd.cs_n && cke_q && mem_cke && pwr_q == PW_ON;
    assign fall_w = cke_q && !mem_cke && pwr_q == PW_ON;
    assign idle_w = op_w == OP_NOP;
    assign pre_w = live_w && op_w == OP_PRE;
    assign pall_w = pre_w && mem_cmd.addr[AP_BIT];
    assign ref_w = live_w && op_w == OP_REF;
    assign mload_w = live_w && op_w == OP_MODE_LOAD;
    assign act_w = live_w && op_w == OP_ACT;
    assign rd_w = live_w && op_w == OP_RD;
    assign wr_w = live_w && op_w == OP_WR;
    assign bst_w = live_w && op_w == OP_BST;
    assign leave_dpd_w = pwr_q == PW_DEEP_PD && mem_cke && cke_q;

    // Stable clock wait restarts after deep power down; see R10
    lpim_cycle_timer #(
        .CYCLES(STABLE_CYCLES)
    ) u_stable (
        .clk(pclk),
        .rst_n(presetn),
        .restart(leave_dpd_w),
        .done(stable_done_w)
    );

    // ----------------------------------------
    // Protocol checking
    // ----------------------------------------
    // Any non-idle command ahead of its init step; see R25
    assign early_w = live_w && !idle_w && (
        (init_q == IN_STABLE && !(stable_done_w && pall_w)) ||
        (init_q == IN_PRECHARGE && !pall_w) ||
        (init_q == IN_SETUP && (act_w || rd_w || wr_w || bst_w)));
    assign stop_early_w = fall_w && init_q != IN_READY; // see R15
    assign ml_busy_w = mload_w && open_q != '0; // see R21
    assign bad_w = early_w || stop_early_w || ml_busy_w;

    // ----------------------------------------
    // Power state
    // ----------------------------------------
    always_comb begin
        pwr_d = pwr_q;
        case (pwr_q)
            PW_ON: begin
                if (fall_w) begin
                    // Entry command rides the falling gate edge; see R2
                    if (!mem_cmd.cs_n && op_w == OP_REF) begin
                        pwr_d = PW_SELF_REF;
                    end else if (!mem_cmd.cs_n && op_w == OP_BST) begin
                        pwr_d = PW_DEEP_PD;
                    end else if (open_q != '0) begin
                        pwr_d = PW_ACT_PD;
                    end else begin
                        pwr_d = PW_PRE_PD;
                    end
                end
            end
            PW_PRE_PD, PW_ACT_PD: begin
                // Needs two high samples; see R3
                if (mem_cke && cke_q) begin
                    pwr_d = PW_ON;
                end
            end
            PW_SELF_REF: begin
                // Exit on first high sample, not qualified; see R3
                if (mem_cke) begin
                    pwr_d = PW_ON;
                end
            end
            PW_DEEP_PD: begin
                if (leave_dpd_w) begin
                    pwr_d = PW_ON;
                end
            end
            default: pwr_d = PW_ON;
        endcase
    end

    // ----------------------------------------
    // Init sequence
    // ----------------------------------------
    // Refreshes and mode loads may come in any order; see R12 R13 R14
    always_comb begin
        init_d = init_q;
        case (init_q)
            IN_STABLE: begin
                if (stable_done_w && pall_w) begin
                    init_d = IN_SETUP;
                end else if (stable_done_w) begin
                    init_d = IN_PRECHARGE;
                end
            end
            IN_PRECHARGE: begin
                if (pall_w) begin
                    init_d = IN_SETUP;
                end
            end
            IN_SETUP: begin
                if (ref_cnt_q == REF_NEED && base_valid_q && ext_valid_q) begin
                    init_d = IN_READY;
                end
            end
            IN_READY: init_d = IN_READY;
            default: init_d = IN_STABLE;
        endcase
        if (leave_dpd_w) begin
            init_d = IN_STABLE;
        end
    end

    // ----------------------------------------
    // Banks and addresses
    // ----------------------------------------
    always_comb begin
        open_d = open_q;
        if (act_w) begin
            open_d[mem_cmd.ba] = 1'b1;
        end else if (pall_w) begin
            open_d = '0;
        end else if (pre_w) begin
            open_d[mem_cmd.ba] = 1'b0;
        end
        if (pwr_d == PW_DEEP_PD) begin
            open_d = '0;
        end
    end

    function automatic logic [3:0] beats_of(input logic [2:0] bl);
        case (bl)
            BL_2: beats_of = 4'h1;
            BL_4: beats_of = 4'h2;
            BL_8: beats_of = 4'h4;
            BL_16: beats_of = 4'h8;
            default: beats_of = 4'h0;
        endcase
    endfunction

    // Burst length field of the base mode; see R19
    assign beats_w = beats_of(mode_q[MR_BL_LSB +: 3]);
    assign lane_mask_w = wide_q ? LANES_X32 : LANES_X16; // see R6
    assign rd_start_w = rd_w && init_q == IN_READY;
    assign rd_cnt_d = rd_start_w ? beats_w :
                      (rd_cnt_q != 4'h0 ? rd_cnt_q - 4'h1 : 4'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_q <= PW_ON;
            init_q <= IN_STABLE;
            cke_q <= 1'b0;
            open_q <= '0;
            rd_cnt_q <= 4'h0;
        end else begin
            pwr_q <= pwr_d;
            init_q <= init_d;
            cke_q <= mem_cke;
            open_q <= open_d;
            rd_cnt_q <= rd_cnt_d;
        end
    end

    // Mode store; no usable default until loaded; see R14 R17 R22
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= '0;
            base_valid_q <= 1'b0;
            ext_valid_q <= 1'b0;
        end else if (pwr_d == PW_DEEP_PD) begin
            base_valid_q <= 1'b0; // see R18
            ext_valid_q <= 1'b0;
        end else if (mload_w && mem_cmd.ba == BA_BASE) begin
            mode_q <= mem_cmd.addr;
            base_valid_q <= 1'b1;
        end else if (mload_w && mem_cmd.ba == BA_EXT) begin
            ext_valid_q <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_cnt_q <= 2'h0;
        end else if (leave_dpd_w) begin
            ref_cnt_q <= 2'h0;
        end else if (ref_w && init_q == IN_SETUP && ref_cnt_q != REF_NEED) begin
            ref_cnt_q <= ref_cnt_q + 2'h1;
        end
    end

    // Column width follows the lane configuration; see R7 R8
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            col_addr_q <= '0;
            row_addr_q <= '0;
        end else if (rd_w || wr_w) begin
            col_addr_q <= wide_q ? {1'b0, mem_cmd.addr[COL_W32-1:0]}
                                 : mem_cmd.addr[COL_W16-1:0];
        end else if (act_w) begin
            row_addr_q <= mem_cmd.addr;
        end
    end

    // Buffers and drivers follow the power state, strobe drive the read burst; see R1 R4 R5
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_en_q <= 1'b0;
            inbuf_en_q <= 1'b0;
            outdrv_en_q <= 1'b0;
            strobe_oe_q <= '0;
        end else begin
            clk_en_q <= pwr_d == PW_ON && mem_cke;
            inbuf_en_q <= pwr_d == PW_ON;
            outdrv_en_q <= pwr_d == PW_ON && mem_cke;
            strobe_oe_q <= rd_cnt_d != 4'h0 ? lane_mask_w : 4'h0;
        end
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    logic setup_w, wr_en_w, hit_w, ctrl_wr_w, err_clr_w;
    lpim_status_t status_w;
    lpim_mode_rd_t mode_rd_w;
    logic [31:0] rd_mux_w;

    assign setup_w = psel && !penable;
    assign wr_en_w = psel && penable && pready_q && pwrite;
    assign hit_w = paddr == REG_CTRL || paddr == REG_STATUS ||
                   paddr == REG_MODE || paddr == REG_BANKS;
    assign ctrl_wr_w = wr_en_w && paddr == REG_CTRL;
    assign err_clr_w = ctrl_wr_w && pwdata[CTRL_ERRCLR_BIT];

    assign status_w = '{pad: '0, clk_stop_ok: init_q == IN_READY,
                        pwr: pwr_q, stable_done: stable_done_w,
                        pre_seen: init_q == IN_SETUP || init_q == IN_READY,
                        ref_cnt: ref_cnt_q, ext_valid: ext_valid_q,
                        base_valid: base_valid_q, err: err_q,
                        init_done: init_q == IN_READY};
    assign mode_rd_w = '{valid: base_valid_q, pad: '0, opcode: mode_q};
    assign rd_mux_w = paddr == REG_CTRL ? 32'(wide_q) :
                      paddr == REG_STATUS ? 32'(status_w) :
                      paddr == REG_MODE ? 32'(mode_rd_w) :
                      paddr == REG_BANKS ? 32'(open_q) : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= setup_w;
            pslverr_q <= setup_w && !hit_w;
            prdata_q <= setup_w ? rd_mux_w : prdata_q;
        end
    end

    // Error flag: a new fault wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_q <= 1'b0;
            wide_q <= 1'b0;
        end else begin
            err_q <= bad_w || (err_q && !err_clr_w);
            wide_q <= ctrl_wr_w ? pwdata[CTRL_WIDE_BIT] : wide_q;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign clk_en = clk_en_q;
    assign inbuf_en = inbuf_en_q;
    assign outdrv_en = outdrv_en_q;
    assign strobe_oe = strobe_oe_q;
    assign col_addr = col_addr_q;
    assign row_addr = row_addr_q;
    assign cmd_err = err_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence rd_issue;
        rd_start_w && beats_w != 4'h0;
    endsequence

    sequence apb_setup;
        psel && !penable;
    endsequence

    sref_exit_a: assert property (pwr_q == PW_SELF_REF && mem_cke // see R3
        |=> pwr_q == PW_ON) else $error("self refresh exit late");
    pd_exit_a: assert property (pwr_q == PW_PRE_PD && mem_cke // see R3
        && !cke_q |=> pwr_q == PW_PRE_PD)
        else $error("power down exit early");
    act_pd_a: assert property (fall_w && open_q != '0 // see R2
        && (mem_cmd.cs_n || idle_w) |=> pwr_q == PW_ACT_PD)
        else $error("no active power down");
    bufs_off_a: assert property (pwr_q != PW_ON |-> !inbuf_en_q // see R4
        && !outdrv_en_q && !clk_en_q)
        else $error("buffers on in power down");
    early_cmd_a: assert property (init_q == IN_STABLE // see R25
        && !stable_done_w && live_w && !idle_w
        |=> err_q [*2] or (err_q ##1 err_clr_w))
        else $error("early command not flagged");
    base_load_a: assert property (mload_w && mem_cmd.ba == BA_BASE // see R17
        |=> mode_q == $past(mem_cmd.addr) && base_valid_q)
        else $error("base mode not stored");
    cs_mask_a: assert property (mem_cmd.cs_n && pwr_q == PW_ON // see R23
        && !fall_w |=> $stable(open_q) && $stable(mode_q))
        else $error("deselected command acted");
    dpd_loss_a: assert property (pwr_q == PW_DEEP_PD // see R18
        |-> !base_valid_q) else $error("mode kept in deep power down");
    rd_strobe_a: assert property (rd_issue // see R5
        |=> strobe_oe_q == $past(lane_mask_w))
        else $error("read strobe not driven");
    clk_stop_a: assert property (stop_early_w // see R15
        |=> err_q) else $error("early clock stop not flagged");
    col_wide_a: assert property (rd_w && wide_q // see R8
        |=> col_addr_q[9] == 1'b0) else $error("wide column too wide");
    apb_ready_a: assert property (apb_setup |=> pready_q ##1 !pready_q ||
        $past(setup_w)) else $error("apb ready timing wrong");

endmodule

/* File: verif/lpim_ctrl_model.sv */
// Memory controller stand-in driving clock gate and command pins.
// Assumes the testbench calls its tasks from one process on pclk.
`timescale 1ns/1ps
module lpim_ctrl_model #(
    parameter int PRE_WAIT = 2, // Precharge wait in cycles
    parameter int REF_WAIT = 4, // Refresh cycle wait in cycles
    parameter int MODE_WAIT = 2 // Mode load wait in cycles
) (
    input wire logic pclk, // Clock
    output lpim_pkg::lpim_cmd_t mem_cmd, // Command and address pins
    output logic mem_cke // Clock gate
);
    import lpim_pkg::*;

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    initial begin
        mem_cke = 1'b1;
        mem_cmd = '{1'b0, 1'b1, 1'b1, 1'b1, 2'h0, 13'h0};
    end

    // One command cycle, then a nop; unused lines show the inverse
    task automatic send(input logic [2:0] op, input logic [1:0] ba,
                        input logic [12:0] a, input logic cs_n,
                        input logic k);
        @(posedge pclk);
        mem_cke <= k;
        mem_cmd <= '{cs_n, op[2], op[1], op[0], ba, a};
        @(posedge pclk);
        mem_cmd <= '{1'b0, 1'b1, 1'b1, 1'b1, ~ba, ~a};
    endtask

    task automatic set_cke(input logic k);
        @(posedge pclk);
        mem_cke <= k;
    endtask

    // ----------------------------------------
    // Init steps after the stable-clock wait
    // ----------------------------------------
    task automatic init_seq(input logic [12:0] opcode);
        send(OP_PRE, 2'h0, 13'h1 << AP_BIT, 1'b0, 1'b1);
        repeat (PRE_WAIT) @(posedge pclk);
        for (int i = 0; i < 2; i++) begin
            send(OP_REF, 2'h0, 13'h0, 1'b0, 1'b1);
            repeat (REF_WAIT) @(posedge pclk);
        end
        send(OP_MODE_LOAD, BA_BASE, opcode, 1'b0, 1'b1);
        repeat (MODE_WAIT) @(posedge pclk);
        send(OP_MODE_LOAD, BA_EXT, 13'h0, 1'b0, 1'b1);
        repeat (MODE_WAIT) @(posedge pclk);
    endtask
endmodule

/* File: verif/testbench.sv */
// Self-checking bench: APB register reads plus controller command traffic.
// Assumes the short stable-clock count set below.
`timescale 1ns/1ps
module testbench;
    import lpim_pkg::*;
    localparam int STAB = 20;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, e, clk_en, inbuf_en, outdrv_en, cmd_err;
    logic mem_cke;
    lpim_cmd_t mem_cmd;
    logic [3:0] strobe_oe;
    logic [9:0] col_addr;
    logic [12:0] row_addr;
    int errors = 0;
    int compares = 0;

    always #5 pclk = ~pclk;

    lpim_core #(.STABLE_CYCLES(STAB)) u_lpim_core (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_cke(mem_cke), .mem_cmd(mem_cmd),
        .clk_en(clk_en), .inbuf_en(inbuf_en), .outdrv_en(outdrv_en),
        .strobe_oe(strobe_oe), .col_addr(col_addr), .row_addr(row_addr),
        .cmd_err(cmd_err));
    lpim_ctrl_model u_lpim_ctrl_model (.pclk(pclk), .mem_cmd(mem_cmd),
        .mem_cke(mem_cke));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic final_report;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] x);
        compares++;
        if (s !== x) begin
            errors++;
            $display("[ERR] %s exp %h seen %h", nm, x, s);
        end
    endtask

    // Holds the request until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (pready !== 1'b1) begin
            errors++;
            final_report();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cmd(input logic [2:0] op, input logic [12:0] a,
                       input logic k);
        u_lpim_ctrl_model.send(op, 2'h0, a, 1'b0, k);
    endtask

    // Counts strobe cycles after a read and checks the lane pattern
    task automatic burst(input string nm, input logic [3:0] lanes);
        int n;
        logic [3:0] s;
        n = 0;
        s = 4'h0;
        #1;
        repeat (6) begin
            if (strobe_oe !== 4'h0) begin
                n++;
                s = strobe_oe;
            end
            @(posedge pclk);
            #1;
        end
        chk(nm, {28'h0, s}, {28'h0, lanes});
        chk(nm, n, 2);
    endtask

    task automatic wake(input logic [2:0] code, input logic exp_early);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("pwr_state", q[10:8], code);
        chk("inbuf_off", {inbuf_en, clk_en, outdrv_en}, 3'h0);
        u_lpim_ctrl_model.set_cke(1'b1);
        @(posedge pclk);
        #1;
        chk("wake_early", clk_en, exp_early);
        @(posedge pclk);
        #1;
        chk("wake_late", clk_en, 1'b1);
    endtask

    // Waits out the stable-clock count, then runs the init steps
    task automatic boot(input string nm);
        q = 32'h0;
        for (int i = 0; i < 40 && q[7] !== 1'b1; i++)
            apb(1'b0, REG_STATUS, 32'h0);
        chk("stable_wait", q[7], 1'b1);
        u_lpim_ctrl_model.init_seq({6'h0, 7'h32});
        apb(1'b0, REG_STATUS, 32'h0);
        chk(nm, q[11:0], 12'h8ed);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, REG_MODE, 32'h0);
        chk("mode_no_default", q[31], 1'b0);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped_err", {31'h0, e}, 32'h1);
        chk("unmapped_data", q, 32'h0);
        u_lpim_ctrl_model.send(OP_REF, 2'h0, 13'h0, 1'b1, 1'b1);
        repeat (2) @(posedge pclk);
        chk("err_cs_high", cmd_err, 1'b0);
        cmd(OP_REF, 13'h0, 1'b1);
        repeat (2) @(posedge pclk);
        chk("err_early", cmd_err, 1'b1);
        apb(1'b1, REG_CTRL, 32'h2);
        repeat (2) @(posedge pclk);
        chk("err_clear", cmd_err, 1'b0);
        cmd(OP_NOP, 13'h0, 1'b0);
        wake(3'h1, 1'b0);
        chk("err_stop", cmd_err, 1'b1);
        apb(1'b1, REG_CTRL, 32'h2);
        boot("init_status");
        apb(1'b0, REG_MODE, 32'h0);
        chk("base_mode", q, 32'h8000_0032);
        cmd(OP_ACT, 13'h1abc, 1'b1);
        cmd(OP_RD, 13'h3ff, 1'b1);
        burst("strobe_x16", LANES_X16);
        chk("row_addr", row_addr, 13'h1abc);
        chk("col_x16", col_addr, 10'h3ff);
        apb(1'b1, REG_CTRL, 32'h1);
        cmd(OP_RD, 13'h3ff, 1'b1);
        burst("strobe_x32", LANES_X32);
        chk("col_x32", col_addr, 10'h1ff);
        cmd(OP_NOP, 13'h0, 1'b0);
        wake(3'h2, 1'b0);
        cmd(OP_PRE, 13'h1 << AP_BIT, 1'b1);
        cmd(OP_NOP, 13'h0, 1'b0);
        wake(3'h1, 1'b0);
        cmd(OP_REF, 13'h0, 1'b0);
        wake(3'h3, 1'b1);
        apb(1'b0, REG_MODE, 32'h0);
        chk("mode_kept", q, 32'h8000_0032);
        cmd(OP_BST, 13'h0, 1'b0);
        apb(1'b0, REG_MODE, 32'h0);
        chk("mode_deep_pd", q[31], 1'b0);
        u_lpim_ctrl_model.set_cke(1'b1);
        repeat (2) @(posedge pclk);
        boot("reinit_status");
        final_report();
    end
endmodule
